// >>> tff_map.svh
// register offsets, field positions, reset values and sizes of the transceive frame formatter
// assumes a 32-bit classic wishbone slave with byte addresses
// Overview of operation
// [R1] host puts bit count of final sent byte in flag byte bits 3:0
// [R2] split frame: first reply byte carries eight minus significant-bit-count bits
// [R3] split frame: first received byte padded with zeros in its low bits
// [R4] split frame: last received byte padded with zeros in its high bits
// [R5] raw parity: host codes each sent byte's parity inside the payload itself
// [R6] raw parity: no parity check, each data byte followed by its parity byte
// [R7] parity byte is 0x80 for parity one, 0x00 for zero
// [R8] reply opens with result code 80, then length of following field, then data
// [R9] vicinity replies append received crc and status: bit1 crc error, bit0 collision
// [R10] flag byte: bit7 legacy send, bit6 split, bit5 append crc, bit4 raw parity
// [R11] host reads collision indexes only when the collision bit is set
`ifndef TFF_MAP_SVH
`define TFF_MAP_SVH

`define TFF_ADR_CTRL      8'h00
`define TFF_ADR_STATE     8'h04
`define TFF_ADR_IRQ_STAT  8'h08
`define TFF_ADR_IRQ_MASK  8'h0c

`define TFF_CTRL_W        10
`define TFF_CTRL_RST      10'h000
`define TFF_SIG_HI        3
`define TFF_SIG_LO        0
`define TFF_BIT_RAWPAR    4
`define TFF_BIT_CRCAPP    5
`define TFF_BIT_SPLIT     6
`define TFF_BIT_LEGACY    7
`define TFF_BIT_VICINITY  8
`define TFF_BIT_ENABLE    9

`define TFF_STATE_ST_LO   0
`define TFF_STATE_CNT_LO  4
`define TFF_STATE_RD_LO   12

`define TFF_IRQ_W         3
`define TFF_IRQ_DONE      0
`define TFF_IRQ_OVF       1
`define TFF_IRQ_RXERR     2
`define TFF_IRQ_RST       3'h0

`define TFF_RESULT_OK     8'h80
`define TFF_PAR_ONE       8'h80
`define TFF_PAR_ZERO      8'h00
`define TFF_STAT_CRC      1
`define TFF_STAT_COLL     0

`define TFF_DEPTH         64
`define TFF_IDX_W         6
`define TFF_CNT_W         7

`endif

// >>> tff_pkg.sv
// types of the transceive frame formatter
// assumes tff_map.svh for sizes
`include "tff_map.svh"
package tff_pkg;

	typedef enum logic [2:0] {
		TFF_IDLE    = 3'h0,
		TFF_COLLECT = 3'h1,
		TFF_APPEND  = 3'h3,
		TFF_CODE    = 3'h2,
		TFF_LEN     = 3'h6,
		TFF_DATA    = 3'h7
	} tff_state_e;

	typedef struct packed {
		logic                                   first;
		logic                                   valid;
		logic [7:0]                             data;
		logic [7:0]                             par;
		logic                                   last;
		logic [15:0]                            crc;
		logic                                   crc_err;
		logic                                   coll;
	} tff_shape_s;

	typedef struct packed {
		tff_state_e                             st;
		logic [`TFF_CTRL_W-1:0]                 ctrl;
		logic [`TFF_IRQ_W-1:0]                  stat;
		logic [`TFF_IRQ_W-1:0]                  mask;
		logic                                   ack;
		logic [31:0]                            rdat;
		logic                                   irq;
		logic                                   rx_ready;
		logic                                   last_in;
		logic                                   rsp_valid;
		logic [7:0]                             rsp_data;
		logic                                   rsp_last;
		logic [`TFF_CNT_W-1:0]                  cnt;
		logic [`TFF_CNT_W-1:0]                  rd;
		logic [15:0]                            crc;
		logic                                   crc_err;
		logic                                   coll;
		logic [`TFF_DEPTH-1:0][7:0]             mem;
	} tff_main_s;

endpackage

// >>> tff_fmt_if.sv
// carrier of shaped reply bytes from the receive shaper to the reply builder
// assumes both ends share clk
`timescale 1ns/1ps
interface tff_fmt_if;
	logic        valid;
	logic [7:0]  data;
	logic [7:0]  par;
	logic        last;
	logic [15:0] crc;
	logic        crc_err;
	logic        coll;

	modport shaper (output valid, output data, output par, output last,
		output crc, output crc_err, output coll);
	modport builder (input valid, input data, input par, input last,
		input crc, input crc_err, input coll);
endinterface

// >>> tff_rx_shaper.sv
// pads received bytes and derives parity bytes, one register stage
// assumes rx bits arrive right aligned in rx_data, rx_nbits 0 meaning a full byte
`timescale 1ns/1ps
`include "tff_map.svh"
module tff_rx_shaper (
	input  wire logic        clk,
	input  wire logic        reset,
	input  wire logic        take,
	input  wire logic [7:0]  rx_data,
	input  wire logic [3:0]  rx_nbits,
	input  wire logic        rx_par,
	input  wire logic        rx_last,
	input  wire logic [15:0] rx_crc,
	input  wire logic        rx_crc_err,
	input  wire logic        rx_coll,
	input  wire logic        cfg_split,
	input  wire logic [3:0]  cfg_sig,
	tff_fmt_if.shaper        fmt
);
	tff_pkg::tff_shape_s s_ff;
	tff_pkg::tff_shape_s nxt_s;

	always_comb begin
		logic [7:0] keep;
		keep = 8'hff;
		nxt_s = s_ff;
		nxt_s.valid = 1'b0;
		if (take) begin
			nxt_s.valid = 1'b1;
			nxt_s.data = rx_data;
			nxt_s.par = rx_par ? `TFF_PAR_ONE : `TFF_PAR_ZERO; // R7
			nxt_s.last = rx_last;
			nxt_s.crc = rx_crc;
			nxt_s.crc_err = rx_crc_err;
			nxt_s.coll = rx_coll;
			if (cfg_split && cfg_sig != 4'h0 && cfg_sig < 4'h8) begin
				if (s_ff.first) begin
					// first byte holds 8 - sig bits; shift them up so the low bits read zero
					nxt_s.data = rx_data << cfg_sig[2:0]; // R2 R3
				end else if (rx_last && rx_nbits != 4'h0 && rx_nbits < 4'h8) begin
					keep = ~(8'hff << rx_nbits[2:0]);
					nxt_s.data = rx_data & keep; // R4
				end
			end
			nxt_s.first = rx_last;
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			s_ff <= '{first: 1'b1, default: '0};
		end else begin
			s_ff <= nxt_s;
		end
	end

	assign fmt.valid   = s_ff.valid;
	assign fmt.data    = s_ff.data;
	assign fmt.par     = s_ff.par;
	assign fmt.last    = s_ff.last;
	assign fmt.crc     = s_ff.crc;
	assign fmt.crc_err = s_ff.crc_err;
	assign fmt.coll    = s_ff.coll;
endmodule // tff_rx_shaper

// >>> tff_top.sv
// transceive reply builder: collects a received frame, then streams result code,
// length and the formatted data field out to the command interface
// assumes wishbone classic master and a receive decoder synchronous to clk
//
// Decided for this implementation: the register offsets and the Wishbone register port.
`timescale 1ns/1ps
`include "tff_map.svh"
module tff_top (
	input  wire logic        clk,
	input  wire logic        reset,
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [7:0]  wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic      [31:0] wb_dat_o,
	output logic             wb_ack_o,
	output logic             irq,
	input  wire logic        rx_valid,
	output logic             rx_ready,
	input  wire logic [7:0]  rx_data,
	input  wire logic [3:0]  rx_nbits,
	input  wire logic        rx_par,
	input  wire logic        rx_last,
	input  wire logic [15:0] rx_crc,
	input  wire logic        rx_crc_err,
	input  wire logic        rx_coll,
	output logic             rsp_valid,
	input  wire logic        rsp_ready,
	output logic      [7:0]  rsp_data,
	output logic             rsp_last
);
	tff_pkg::tff_main_s m_ff;
	tff_pkg::tff_main_s nxt_m;
	tff_fmt_if          fmt ();
	logic               take;

	assign take = rx_valid & m_ff.rx_ready;

	tff_rx_shaper u_shaper (
		.clk        (clk),
		.reset      (reset),
		.take       (take),
		.rx_data    (rx_data),
		.rx_nbits   (rx_nbits),
		.rx_par     (rx_par),
		.rx_last    (rx_last),
		.rx_crc     (rx_crc),
		.rx_crc_err (rx_crc_err),
		.rx_coll    (rx_coll),
		.cfg_split  (m_ff.ctrl[`TFF_BIT_SPLIT]),
		.cfg_sig    (m_ff.ctrl[`TFF_SIG_HI:`TFF_SIG_LO]), // R1
		.fmt        (fmt)
	);

	always_comb begin
		logic                   wr;
		logic                   rd_req;
		logic                   hit_ctrl;
		logic                   hit_stat;
		logic                   hit_mask;
		logic [`TFF_IRQ_W-1:0]  set;
		logic [`TFF_IRQ_W-1:0]  clr;
		logic [`TFF_CNT_W-1:0]  need;
		logic [`TFF_IDX_W-1:0]  wi;
		logic                   hs;
		logic [31:0]            state_word;
		wr = 1'b0;
		rd_req = 1'b0;
		hit_ctrl = (wb_adr_i == `TFF_ADR_CTRL);
		hit_stat = (wb_adr_i == `TFF_ADR_IRQ_STAT);
		hit_mask = (wb_adr_i == `TFF_ADR_IRQ_MASK);
		set = '0;
		clr = '0;
		need = '0;
		wi = '0;
		hs = 1'b0;
		state_word = 32'h00000000;
		nxt_m = m_ff;
		nxt_m.ack = 1'b0;

		// read-only progress view, so software can see a stuck reply without a probe
		state_word[`TFF_STATE_ST_LO +: 3] = m_ff.st;
		state_word[`TFF_STATE_CNT_LO +: `TFF_CNT_W] = m_ff.cnt;
		state_word[`TFF_STATE_RD_LO +: `TFF_CNT_W] = m_ff.rd;

		// bus slave: answers one cycle after the request, drops ack the cycle after
		if (wb_cyc_i && wb_stb_i && !m_ff.ack) begin
			nxt_m.ack = 1'b1;
			wr = wb_we_i;
			rd_req = !wb_we_i;
		end
		if (wr && hit_ctrl) begin
			if (wb_sel_i[0]) begin
				nxt_m.ctrl[7:0] = wb_dat_i[7:0]; // R10
			end
			if (wb_sel_i[1]) begin
				nxt_m.ctrl[`TFF_CTRL_W-1:8] = wb_dat_i[`TFF_CTRL_W-1:8];
			end
		end
		if (wr && hit_mask && wb_sel_i[0]) begin
			nxt_m.mask = wb_dat_i[`TFF_IRQ_W-1:0];
		end
		if (wr && hit_stat && wb_sel_i[0]) begin
			clr = wb_dat_i[`TFF_IRQ_W-1:0];
		end
		if (rd_req) begin
			unique case (wb_adr_i)
				`TFF_ADR_CTRL: begin
					nxt_m.rdat = {{(32-`TFF_CTRL_W){1'b0}}, m_ff.ctrl};
				end
				`TFF_ADR_STATE: begin
					nxt_m.rdat = state_word;
				end
				`TFF_ADR_IRQ_STAT: begin
					nxt_m.rdat = {29'h0000000, m_ff.stat};
				end
				`TFF_ADR_IRQ_MASK: begin
					nxt_m.rdat = {29'h0000000, m_ff.mask};
				end
				default: begin
					nxt_m.rdat = 32'h00000000;
				end
			endcase
		end

		if (take && rx_last) begin
			nxt_m.last_in = 1'b1;
		end
		hs = m_ff.rsp_valid && rsp_ready;

		unique case (m_ff.st)
			tff_pkg::TFF_IDLE: begin
				nxt_m.cnt = '0;
				nxt_m.rd = '0;
				if (take) begin
					nxt_m.st = tff_pkg::TFF_COLLECT;
				end
			end
			tff_pkg::TFF_COLLECT: begin
				if (fmt.valid) begin
					// raw parity doubles every byte; the device never checks parity then
					need = m_ff.ctrl[`TFF_BIT_RAWPAR] ? 7'h02 : 7'h01; // R6
					wi = m_ff.cnt[`TFF_IDX_W-1:0];
					if (m_ff.cnt + need <= 7'(`TFF_DEPTH)) begin
						nxt_m.mem[wi] = fmt.data;
						if (m_ff.ctrl[`TFF_BIT_RAWPAR]) begin
							nxt_m.mem[wi + 6'h01] = fmt.par; // R6 R7
						end
						nxt_m.cnt = m_ff.cnt + need;
					end else begin
						set[`TFF_IRQ_OVF] = 1'b1;
					end
					if (fmt.last) begin
						nxt_m.crc = fmt.crc;
						nxt_m.crc_err = fmt.crc_err;
						nxt_m.coll = fmt.coll;
						set[`TFF_IRQ_RXERR] = fmt.crc_err | fmt.coll;
						if (m_ff.ctrl[`TFF_BIT_VICINITY]) begin
							nxt_m.st = tff_pkg::TFF_APPEND;
						end else begin
							nxt_m.st = tff_pkg::TFF_CODE;
							nxt_m.rsp_valid = 1'b1;
							nxt_m.rsp_data = `TFF_RESULT_OK; // R8
							nxt_m.rsp_last = 1'b0;
						end
					end
				end
			end
			tff_pkg::TFF_APPEND: begin
				wi = m_ff.cnt[`TFF_IDX_W-1:0];
				if (m_ff.cnt + 7'h03 <= 7'(`TFF_DEPTH)) begin
					// crc goes out in the order it came off the air
					nxt_m.mem[wi] = m_ff.crc[7:0]; // R9
					nxt_m.mem[wi + 6'h01] = m_ff.crc[15:8]; // R9
					nxt_m.mem[wi + 6'h02] = {6'h00, m_ff.crc_err, m_ff.coll}; // R9
					nxt_m.cnt = m_ff.cnt + 7'h03;
				end else begin
					set[`TFF_IRQ_OVF] = 1'b1;
				end
				nxt_m.st = tff_pkg::TFF_CODE;
				nxt_m.rsp_valid = 1'b1;
				nxt_m.rsp_data = `TFF_RESULT_OK; // R8
				nxt_m.rsp_last = 1'b0;
			end
			tff_pkg::TFF_CODE: begin
				if (hs) begin
					nxt_m.st = tff_pkg::TFF_LEN;
					nxt_m.rsp_data = {1'b0, m_ff.cnt}; // R8
					nxt_m.rsp_last = (m_ff.cnt == '0);
				end
			end
			tff_pkg::TFF_LEN: begin
				if (hs) begin
					if (m_ff.cnt == '0) begin
						nxt_m.st = tff_pkg::TFF_IDLE;
						nxt_m.rsp_valid = 1'b0;
						nxt_m.rsp_last = 1'b0;
						nxt_m.last_in = 1'b0;
						set[`TFF_IRQ_DONE] = 1'b1;
					end else begin
						nxt_m.st = tff_pkg::TFF_DATA;
						nxt_m.rsp_data = m_ff.mem[0];
						nxt_m.rd = 7'h01;
						nxt_m.rsp_last = (m_ff.cnt == 7'h01);
					end
				end
			end
			tff_pkg::TFF_DATA: begin
				if (hs) begin
					if (m_ff.rd == m_ff.cnt) begin
						nxt_m.st = tff_pkg::TFF_IDLE;
						nxt_m.rsp_valid = 1'b0;
						nxt_m.rsp_last = 1'b0;
						nxt_m.last_in = 1'b0;
						set[`TFF_IRQ_DONE] = 1'b1;
					end else begin
						nxt_m.rsp_data = m_ff.mem[m_ff.rd[`TFF_IDX_W-1:0]];
						nxt_m.rd = m_ff.rd + 7'h01;
						nxt_m.rsp_last = (m_ff.rd + 7'h01 == m_ff.cnt);
					end
				end
			end
			default: begin
				nxt_m.st = tff_pkg::TFF_IDLE;
			end
		endcase

		// set beats clear when both land in one cycle
		nxt_m.stat = (m_ff.stat & ~clr) | set;
		nxt_m.irq = |(nxt_m.stat & nxt_m.mask);
		// one frame at a time: receive stalls from the last byte until the reply is out
		nxt_m.rx_ready = nxt_m.ctrl[`TFF_BIT_ENABLE] && !nxt_m.last_in &&
			(nxt_m.st == tff_pkg::TFF_IDLE || nxt_m.st == tff_pkg::TFF_COLLECT);
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			// every member named, so a new struct field cannot slip in without a reset value
			m_ff <= '{
				st:        tff_pkg::TFF_IDLE,
				ctrl:      `TFF_CTRL_RST,
				stat:      `TFF_IRQ_RST,
				mask:      `TFF_IRQ_RST,
				ack:       1'b0,
				rdat:      32'h00000000,
				irq:       1'b0,
				rx_ready:  1'b0,
				last_in:   1'b0,
				rsp_valid: 1'b0,
				rsp_data:  8'h00,
				rsp_last:  1'b0,
				cnt:       7'h00,
				rd:        7'h00,
				crc:       16'h0000,
				crc_err:   1'b0,
				coll:      1'b0,
				mem:       '0
			};
		end else begin
			m_ff <= nxt_m;
		end
	end

	assign wb_dat_o  = m_ff.rdat;
	assign wb_ack_o  = m_ff.ack;
	assign irq       = m_ff.irq;
	assign rx_ready  = m_ff.rx_ready;
	assign rsp_valid = m_ff.rsp_valid;
	assign rsp_data  = m_ff.rsp_data;
	assign rsp_last  = m_ff.rsp_last;
endmodule // tff_top

// >>> tff_top_props.sv
// concurrent checks on the reply builder top ports
// assumes one clock domain with synchronous active-high reset
`timescale 1ns/1ps
module tff_top_props (
	input wire logic       clk,
	input wire logic       reset,
	input wire logic       wb_cyc_i,
	input wire logic       wb_stb_i,
	input wire logic       wb_ack_o,
	input wire logic       rx_valid,
	input wire logic       rx_ready,
	input wire logic       rx_last,
	input wire logic       rsp_valid,
	input wire logic       rsp_ready,
	input wire logic [7:0] rsp_data,
	input wire logic       rsp_last
);
	logic req;
	logic rx_end;
	assign req = wb_cyc_i & wb_stb_i;
	assign rx_end = rx_valid & rx_ready & rx_last;
	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);
	AST_ACK_PULSE: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack held past one cycle");
	AST_ACK_AFTER_REQ: assert property (req && !wb_ack_o |=> wb_ack_o)
		else $error("request not acked next cycle");
	AST_ACK_CAUSE: assert property (wb_ack_o |-> $past(req))
		else $error("ack without request");
	AST_RSP_HOLD: assert property (rsp_valid && !rsp_ready |=> rsp_valid && $stable(rsp_data))
		else $error("reply byte changed while stalled");
	AST_RSP_CODE: assert property ($rose(rsp_valid) |-> rsp_data == 8'h80)
		else $error("reply not opened by result code");
	AST_RSP_END: assert property (rsp_valid && rsp_ready && rsp_last |=> !rsp_valid)
		else $error("reply continues after last byte");
	AST_RX_STOP: assert property (rx_end |=> !rx_ready)
		else $error("receive open after frame end");
	AST_RX_REPLY: assert property (rx_end |-> ##[1:4] rsp_valid)
		else $error("reply late after frame end");
	AST_NO_OVERLAP: assert property (rsp_valid |-> !rx_ready)
		else $error("receive open during reply");
	COV_REPLY: cover property (rsp_valid && rsp_ready && rsp_last);
	COV_STALL: cover property (rsp_valid && !rsp_ready);
	COV_FRAME: cover property (rx_end);
endmodule // tff_top_props

bind tff_top tff_top_props u_props (.clk(clk), .reset(reset), .wb_cyc_i(wb_cyc_i),
	.wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .rx_valid(rx_valid), .rx_ready(rx_ready),
	.rx_last(rx_last), .rsp_valid(rsp_valid), .rsp_ready(rsp_ready), .rsp_data(rsp_data),
	.rsp_last(rsp_last));

// >>> tff_host_model.sv
// host side taking reply bytes, stalling one cycle in four
// assumes clk shared with the formatter
`timescale 1ns/1ps
module tff_host_model (
	input wire logic       clk,
	input wire logic       reset,
	input wire logic       rsp_valid,
	input wire logic [7:0] rsp_data,
	input wire logic       rsp_last,
	output logic           rsp_ready
);
	logic [7:0] got[$];
	logic       lst[$];
	logic [1:0] ph;
	always @(posedge clk) begin
		if (reset) begin
			ph <= 2'h0;
			rsp_ready <= 1'b0;
		end else begin
			ph <= ph + 2'h1;
			rsp_ready <= (ph != 2'h1);
			if (rsp_valid && rsp_ready) begin
				got.push_back(rsp_data);
				lst.push_back(rsp_last);
			end
		end
	end
endmodule // tff_host_model

// >>> tff_top_test.sv
// self-checking bench of the transceive reply builder
// assumes tff_host_model as reply consumer and the bind in tff_top_props.sv
`timescale 1ns/1ps
module tff_top_test;
	logic        clk, reset, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, irq;
	logic [7:0]  wb_adr_i, rx_data, rsp_data;
	logic [3:0]  wb_sel_i, rx_nbits;
	logic [31:0] wb_dat_i, wb_dat_o, rd;
	logic        rx_valid, rx_ready, rx_par, rx_last, rx_crc_err, rx_coll;
	logic [15:0] rx_crc;
	logic        rsp_valid, rsp_ready, rsp_last;
	int          bad_count = 0;
	int          comparisons = 0;
	int          ticks = 0;

	tff_top u_dut (.clk(clk), .reset(reset), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
		.wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
		.wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .irq(irq), .rx_valid(rx_valid),
		.rx_ready(rx_ready), .rx_data(rx_data), .rx_nbits(rx_nbits), .rx_par(rx_par),
		.rx_last(rx_last), .rx_crc(rx_crc), .rx_crc_err(rx_crc_err), .rx_coll(rx_coll),
		.rsp_valid(rsp_valid), .rsp_ready(rsp_ready), .rsp_data(rsp_data), .rsp_last(rsp_last));
	tff_host_model u_host (.clk(clk), .reset(reset), .rsp_valid(rsp_valid),
		.rsp_data(rsp_data), .rsp_last(rsp_last), .rsp_ready(rsp_ready));

	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end

	task automatic final_report();
		$display("comparisons %0d mismatches %0d", comparisons, bad_count);
		if (bad_count == 0 && comparisons > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	always @(posedge clk) begin
		ticks++;
		if (ticks == 20000) begin
			bad_count++;
			final_report();
		end
	end

	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			bad_count++;
			$display("[ERR] %s expected %h seen %h", what, exp, seen);
		end
	endtask

	// classic single cycle; holds everything until ack is sampled high
	task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= we;
		wb_adr_i <= a;
		wb_dat_i <= d;
		do begin
			@(posedge clk);
		end while (wb_ack_o !== 1'b1);
		rd = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
	endtask

	task automatic send(input logic [7:0] d, input logic [3:0] nb, input logic p, input logic l,
		input logic [15:0] c, input logic e, input logic k);
		@(posedge clk);
		rx_valid <= 1'b1;
		rx_data <= d;
		rx_nbits <= nb;
		rx_par <= p;
		rx_last <= l;
		rx_crc <= c;
		rx_crc_err <= e;
		rx_coll <= k;
		do begin
			@(posedge clk);
		end while (rx_ready !== 1'b1);
		rx_valid <= 1'b0;
		rx_data <= ~d;
		rx_crc <= ~c;
	endtask

	task automatic reply(input logic [7:0] e[$]);
		while (u_host.got.size() < e.size()) begin
			@(posedge clk);
		end
		repeat (3) @(posedge clk);
		chk("reply size", 32'(u_host.got.size()), 32'(e.size()));
		foreach (e[i]) begin
			chk("reply byte", {24'h0, u_host.got[i]}, {24'h0, e[i]});
			chk("reply last", {31'h0, u_host.lst[i]}, {31'h0, i == e.size() - 1});
		end
		u_host.got.delete();
		u_host.lst.delete();
	endtask

	task automatic t_regs();
		wb(1'b0, 8'h00, 32'h0);
		chk("ctrl", rd, 32'h0);
		wb(1'b0, 8'h04, 32'h0);
		chk("state idle", rd, 32'h0);
		wb(1'b1, 8'h00, 32'h1f5);
		wb(1'b0, 8'h00, 32'h0);
		chk("ctrl flags", rd, 32'h1f5);
		wb(1'b0, 8'h08, 32'h0);
		chk("irq status", rd, 32'h0);
		wb(1'b0, 8'h10, 32'h0);
		chk("unmapped", rd, 32'h0);
		wb(1'b1, 8'h0c, 32'h1);
		wb(1'b0, 8'h0c, 32'h0);
		chk("irq mask", rd, 32'h1);
		$display("test regs done");
	endtask

	task automatic t_parity();
		wb(1'b1, 8'h00, 32'h210);
		send(8'h32, 4'h0, 1'b1, 1'b0, 16'h0, 1'b0, 1'b0);
		send(8'h34, 4'h0, 1'b0, 1'b1, 16'h0, 1'b0, 1'b0);
		reply('{8'h80, 8'h04, 8'h32, 8'h80, 8'h34, 8'h00});
		chk("irq raised", {31'h0, irq}, 32'h1);
		wb(1'b1, 8'h08, 32'h1);
		wb(1'b0, 8'h08, 32'h0);
		chk("status cleared", rd, 32'h0);
		chk("irq cleared", {31'h0, irq}, 32'h0);
		$display("test parity done");
	endtask

	task automatic t_split();
		wb(1'b1, 8'h00, 32'h244);
		send(8'h0b, 4'h4, 1'b0, 1'b0, 16'h0, 1'b0, 1'b0);
		send(8'hff, 4'h3, 1'b0, 1'b1, 16'h0, 1'b0, 1'b0);
		reply('{8'h80, 8'h02, 8'hb0, 8'h07});
		wb(1'b1, 8'h08, 32'h7);
		$display("test split done");
	endtask

	task automatic t_vicinity();
		wb(1'b1, 8'h00, 32'h300);
		send(8'haa, 4'h0, 1'b0, 1'b1, 16'h1234, 1'b1, 1'b0);
		reply('{8'h80, 8'h04, 8'haa, 8'h34, 8'h12, 8'h02});
		wb(1'b0, 8'h08, 32'h0);
		chk("status crc", rd, 32'h5);
		wb(1'b1, 8'h0c, 32'h0);
		chk("irq masked", {31'h0, irq}, 32'h0);
		wb(1'b1, 8'h08, 32'h7);
		send(8'h55, 4'h0, 1'b0, 1'b1, 16'habcd, 1'b0, 1'b1);
		reply('{8'h80, 8'h04, 8'h55, 8'hcd, 8'hab, 8'h01});
		$display("test vicinity done");
	endtask

	task automatic t_overflow();
		logic [7:0] e[$];
		e = '{8'h80, 8'h40};
		for (int i = 0; i < 32; i++) begin
			e.push_back(8'(i));
			e.push_back(8'h00);
		end
		wb(1'b1, 8'h08, 32'h7);
		wb(1'b1, 8'h00, 32'h210);
		for (int i = 0; i < 33; i++) begin
			send(8'(i), 4'h0, 1'b0, i == 32, 16'h0, 1'b0, 1'b0);
		end
		reply(e);
		wb(1'b0, 8'h08, 32'h0);
		chk("status overflow", rd, 32'h3);
		$display("test overflow done");
	endtask

	initial begin
		reset = 1'b1;
		{wb_cyc_i, wb_stb_i, wb_we_i, rx_valid, rx_par, rx_last, rx_crc_err, rx_coll} = 8'h00;
		wb_adr_i = 8'h00;
		wb_sel_i = 4'hf;
		wb_dat_i = 32'h0;
		rx_data = 8'h00;
		rx_nbits = 4'h0;
		rx_crc = 16'h0;
		repeat (16) @(posedge clk);
		reset <= 1'b0;
		t_regs();
		t_parity();
		t_split();
		t_vicinity();
		t_overflow();
		final_report();
	end
endmodule // tff_top_test
